// ### design/ppw_pkg.sv
// Package of mode codes and constants for the push-pull and pulse-skipping waveform block
package ppw_pkg;

    // ----------------------------------------
    // Mode selection
    // ----------------------------------------
    typedef enum logic [2:0] {
        PPW_MODE_PP       = 3'h0,
        PPW_MODE_PP_COMP  = 3'h1,
        PPW_MODE_PP_FB4   = 3'h2,
        PPW_MODE_PP_FB6   = 3'h3,
        PPW_MODE_SKIP     = 3'h4,
        PPW_MODE_SKIP_CMP = 3'h5
    } ppw_mode_e;

    // ----------------------------------------
    // Widths and reset values
    // ----------------------------------------
    localparam int unsigned PPW_DB_W       = 8;
    localparam int unsigned PPW_NUM_OUT    = 6;
    localparam int unsigned PPW_NUM_SRC    = 4;
    localparam logic        PPW_ODD_RST    = 1'b1;
    localparam logic [7:0]  PPW_DB_ZERO    = 8'h00;

    // Output indices
    localparam int unsigned PPW_IDX_A = 0;
    localparam int unsigned PPW_IDX_B = 1;
    localparam int unsigned PPW_IDX_C = 2;
    localparam int unsigned PPW_IDX_D = 3;
    localparam int unsigned PPW_IDX_E = 4;
    localparam int unsigned PPW_IDX_F = 5;

endpackage : ppw_pkg

// ### design/ppw_if.sv
// Interface between the waveform core and a dead-band pair driver
`timescale 1ns/1ps
`default_nettype none
interface ppw_pair_if;
    logic       set_p;
    logic       clr_p;
    logic       db_en;
    logic [7:0] db_rise;
    logic [7:0] db_fall;
    logic       pri;
    logic       cmp;
    modport core (output set_p, clr_p, db_en, db_rise, db_fall, input pri, cmp);
    modport pair (input set_p, clr_p, db_en, db_rise, db_fall, output pri, cmp);
endinterface : ppw_pair_if
`default_nettype wire

// ### design/ppw_pair.sv
// Primary/complementary pair with optional dead band on each hand-off
`timescale 1ns/1ps
`default_nettype none
module ppw_pair (
    // Clock, reset and enable
    input  wire logic  core_clk_i,
    input  wire logic  sys_rst_i,
    input  wire logic  enable_i,
    // Core side
    ppw_pair_if.pair   p
);
    import ppw_pkg::*;

    typedef enum logic [1:0] {
        PPW_S_CMP  = 2'b00,
        PPW_S_DBR  = 2'b01,
        PPW_S_PRI  = 2'b11,
        PPW_S_DBF  = 2'b10
    } ppw_pst_e;

    ppw_pst_e            st_q;
    logic [PPW_DB_W-1:0] cnt_q;

    // Complementary off, rising dead band, primary on; mirror on the fall
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_q  <= PPW_S_CMP;
            cnt_q <= PPW_DB_ZERO;
        end else if (!enable_i) begin
            st_q  <= PPW_S_CMP;
            cnt_q <= PPW_DB_ZERO;
        end else if (p.clr_p && (st_q == PPW_S_PRI || st_q == PPW_S_DBR)) begin
            if (p.db_en && p.db_fall != PPW_DB_ZERO) begin
                st_q  <= PPW_S_DBF;
                cnt_q <= p.db_fall;
            end else begin
                st_q  <= PPW_S_CMP;
            end
        end else if (p.set_p && (st_q == PPW_S_CMP || st_q == PPW_S_DBF)) begin
            if (p.db_en && p.db_rise != PPW_DB_ZERO) begin
                st_q  <= PPW_S_DBR;
                cnt_q <= p.db_rise;
            end else begin
                st_q  <= PPW_S_PRI;
            end
        end else begin
            case (st_q)
                PPW_S_DBR: begin
                    if (cnt_q <= 8'h01) begin
                        st_q <= PPW_S_PRI;
                    end
                    cnt_q <= cnt_q - 8'h01;
                end
                PPW_S_DBF: begin
                    if (cnt_q <= 8'h01) begin
                        st_q <= PPW_S_CMP;
                    end
                    cnt_q <= cnt_q - 8'h01;
                end
                default: begin
                    cnt_q <= PPW_DB_ZERO;
                end
            endcase
        end
    end

    assign p.pri = (st_q == PPW_S_PRI);
    assign p.cmp = enable_i && (st_q == PPW_S_CMP);

endmodule : ppw_pair
`default_nettype wire

// ### design/ppw_gen.sv
// Push-pull and pulse-skipping output waveform generator
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Basic push-pull drives A on odd periods, B on even periods.
// - Basic push-pull uses only A and B, no dead band or steering.
// - Odd period rise sets A, fall clears A; even periods same for B.
// - Complementary push-pull drives pair A/E on odd, pair B/F on even periods.
// - Odd period: E off, rising dead band, A on; reverse on fall.
// - Even period: F off, rising dead band, B on; reverse on fall.
// - Four-output push-pull uses A to D only; A equals C, B equals D.
// - Odd events drive A and C together; even events drive B and D.
// - Six-output mode: A to D primaries, E and F complements, dead band allowed.
// - Six-output odd period: E off, dead band, A and C on; reverse on fall.
// - Six-output even period: F off, dead band, B and D on; reverse on fall.
// - Pulse skipping: rise only if an enabled rise source is high at period event.
// - A qualified period sets the primary on the next phase rising event.
// - Pulse skipping: falling events always clear the primary, unqualified.
// - Single pulse skipping drives A only, no dead band or steering.
// - Complementary pulse skipping: A primary, B complement, dead band hand-offs.
// - Each output has its own polarity inversion after waveform generation.
module ppw_gen #(
    parameter int unsigned NUM_SRC = ppw_pkg::PPW_NUM_SRC
) (
    // Clock and reset
    input  wire logic                           core_clk_i,
    input  wire logic                           sys_rst_i,
    // Configuration
    input  wire logic                           enable_i,
    input  wire ppw_pkg::ppw_mode_e             mode_i,
    input  wire logic                           db_rise_en_i,
    input  wire logic                           db_fall_en_i,
    input  wire logic [ppw_pkg::PPW_DB_W-1:0]   db_rise_time_i,
    input  wire logic [ppw_pkg::PPW_DB_W-1:0]   db_fall_time_i,
    input  wire logic [ppw_pkg::PPW_NUM_OUT-1:0] polarity_i,
    // Events
    input  wire logic                           period_evt_i,
    input  wire logic                           rise_evt_i,
    input  wire logic                           fall_evt_i,
    input  wire logic [NUM_SRC-1:0]             rise_src_i,
    input  wire logic [NUM_SRC-1:0]             rise_src_en_i,
    input  wire logic                           phase_rise_evt_i,
    // Status
    output logic                                odd_period_o,
    // Outputs to bridge drivers
    output logic                                pwm_out_a_o,
    output logic                                pwm_out_b_o,
    output logic                                pwm_out_c_o,
    output logic                                pwm_out_d_o,
    output logic                                pwm_out_e_o,
    output logic                                pwm_out_f_o
);
    import ppw_pkg::*;

    // ----------------------------------------
    // Period sequencing
    // ----------------------------------------
    logic odd_q;
    logic skip_armed_q;

    // Toggles on every period event, the first included; first period is odd
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            odd_q <= PPW_ODD_RST;
        end else if (!enable_i) begin
            odd_q <= PPW_ODD_RST;
        end else if (period_evt_i) begin
            odd_q <= ~odd_q;
        end
    end

    // The first period event opens period 1, so the inverse of odd_q names the current period
    logic first_q;
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            first_q <= 1'b1;
        end else if (!enable_i) begin
            first_q <= 1'b1;
        end else if (period_evt_i) begin
            first_q <= 1'b0;
        end
    end

    // Cur period parity: the first period event opens period 1 (odd)
    logic cur_odd;
    assign cur_odd = first_q ? 1'b1 : ~odd_q;

    // ----------------------------------------
    // Pulse-skip qualification
    // ----------------------------------------
    logic qualify;
    assign qualify = |(rise_src_i & rise_src_en_i);

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            skip_armed_q <= 1'b0;
        end else if (!enable_i) begin
            skip_armed_q <= 1'b0;
        end else if (period_evt_i) begin
            skip_armed_q <= qualify;
        end else if (phase_rise_evt_i) begin
            skip_armed_q <= 1'b0;
        end
    end

    logic skip_mode;
    logic skip_set;
    assign skip_mode = (mode_i == PPW_MODE_SKIP) || (mode_i == PPW_MODE_SKIP_CMP);
    assign skip_set  = skip_armed_q && phase_rise_evt_i;

    // ----------------------------------------
    // Event routing to the two pairs
    // ----------------------------------------
    ppw_pair_if odd_if ();
    ppw_pair_if even_if ();

    logic pp_mode;
    logic db_mode;
    assign pp_mode = !skip_mode;
    assign db_mode = (mode_i == PPW_MODE_PP_COMP) || (mode_i == PPW_MODE_PP_FB6)
                     || (mode_i == PPW_MODE_SKIP_CMP);

    always_comb begin
        if (skip_mode) begin
            odd_if.set_p  = skip_set;
            odd_if.clr_p  = fall_evt_i;
        end else begin
            odd_if.set_p  = pp_mode && rise_evt_i && cur_odd;
            odd_if.clr_p  = pp_mode && fall_evt_i && cur_odd;
        end
        even_if.set_p = pp_mode && rise_evt_i && !cur_odd;
        even_if.clr_p = pp_mode && fall_evt_i && !cur_odd;
        odd_if.db_en    = db_mode;
        even_if.db_en   = db_mode;
        odd_if.db_rise  = db_rise_en_i ? db_rise_time_i : PPW_DB_ZERO;
        odd_if.db_fall  = db_fall_en_i ? db_fall_time_i : PPW_DB_ZERO;
        even_if.db_rise = db_rise_en_i ? db_rise_time_i : PPW_DB_ZERO;
        even_if.db_fall = db_fall_en_i ? db_fall_time_i : PPW_DB_ZERO;
    end

    ppw_pair u_odd_pair (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .enable_i   (enable_i),
        .p          (odd_if.pair)
    );

    ppw_pair u_even_pair (
        .core_clk_i (core_clk_i),
        .sys_rst_i  (sys_rst_i),
        .enable_i   (enable_i),
        .p          (even_if.pair)
    );

    // ----------------------------------------
    // Pin mapping per mode
    // ----------------------------------------
    logic [PPW_NUM_OUT-1:0] wave;

    always_comb begin
        wave = '0;
        case (mode_i)
            PPW_MODE_PP: begin
                wave[PPW_IDX_A] = odd_if.pri;
                wave[PPW_IDX_B] = even_if.pri;
            end
            PPW_MODE_PP_COMP: begin
                wave[PPW_IDX_A] = odd_if.pri;
                wave[PPW_IDX_E] = odd_if.cmp;
                wave[PPW_IDX_B] = even_if.pri;
                wave[PPW_IDX_F] = even_if.cmp;
            end
            PPW_MODE_PP_FB4: begin
                wave[PPW_IDX_A] = odd_if.pri;
                wave[PPW_IDX_C] = odd_if.pri;
                wave[PPW_IDX_B] = even_if.pri;
                wave[PPW_IDX_D] = even_if.pri;
            end
            PPW_MODE_PP_FB6: begin
                wave[PPW_IDX_A] = odd_if.pri;
                wave[PPW_IDX_C] = odd_if.pri;
                wave[PPW_IDX_E] = odd_if.cmp;
                wave[PPW_IDX_B] = even_if.pri;
                wave[PPW_IDX_D] = even_if.pri;
                wave[PPW_IDX_F] = even_if.cmp;
            end
            PPW_MODE_SKIP: begin
                wave[PPW_IDX_A] = odd_if.pri;
            end
            PPW_MODE_SKIP_CMP: begin
                wave[PPW_IDX_A] = odd_if.pri;
                wave[PPW_IDX_B] = odd_if.cmp;
            end
            default: begin
                wave = '0;
            end
        endcase
    end

    // ----------------------------------------
    // Polarity and output registers
    // ----------------------------------------
    logic [PPW_NUM_OUT-1:0] out_q;

    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_q <= '0;
        end else begin
            out_q <= wave ^ polarity_i;
        end
    end

    assign odd_period_o = cur_odd;
    assign pwm_out_a_o  = out_q[PPW_IDX_A];
    assign pwm_out_b_o  = out_q[PPW_IDX_B];
    assign pwm_out_c_o  = out_q[PPW_IDX_C];
    assign pwm_out_d_o  = out_q[PPW_IDX_D];
    assign pwm_out_e_o  = out_q[PPW_IDX_E];
    assign pwm_out_f_o  = out_q[PPW_IDX_F];

endmodule : ppw_gen
`default_nettype wire

// ### test/ppw_gate_drv.sv
// Gate driver model for the six bridge outputs
`timescale 1ns/1ps
`default_nettype none
module ppw_gate_drv (
    // Clock and pins
    input  wire logic       core_clk_i,
    input  wire logic [5:0] pin_i,
    // Gate levels
    output logic      [5:0] gate_o
);
    // Gates follow the pins one clock late
    always_ff @(posedge core_clk_i) begin
        gate_o <= pin_i;
    end
endmodule : ppw_gate_drv
`default_nettype wire

// ### test/ppw_gen_props.sv
// Concurrent checks on the waveform generator ports
`timescale 1ns/1ps
`default_nettype none
module ppw_gen_props
    import ppw_pkg::*;
#(
    parameter int unsigned NUM_SRC = 4
) (
    // Clock and reset
    input wire logic               core_clk_i,
    input wire logic               sys_rst_i,
    // Configuration and events
    input wire logic               enable_i,
    input wire ppw_pkg::ppw_mode_e mode_i,
    input wire logic [5:0]         polarity_i,
    input wire logic               period_evt_i,
    input wire logic               rise_evt_i,
    input wire logic               fall_evt_i,
    input wire logic [NUM_SRC-1:0] rise_src_i,
    input wire logic [NUM_SRC-1:0] rise_src_en_i,
    input wire logic               phase_rise_evt_i,
    // Outputs
    input wire logic               odd_period_o,
    input wire logic               pwm_out_a_o,
    input wire logic               pwm_out_b_o,
    input wire logic               pwm_out_c_o,
    input wire logic               pwm_out_d_o,
    input wire logic               pwm_out_e_o,
    input wire logic               pwm_out_f_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    logic [5:0] pins;
    logic       qual;
    assign pins = {pwm_out_f_o, pwm_out_e_o, pwm_out_d_o, pwm_out_c_o, pwm_out_b_o, pwm_out_a_o};
    assign qual = |(rise_src_i & rise_src_en_i);
    sequence s_clean;
        enable_i && polarity_i == 6'h00 && $stable(polarity_i) && $stable(mode_i);
    endsequence
    sequence s_skip;
        s_clean ##0 (mode_i == PPW_MODE_SKIP && period_evt_i && !pwm_out_a_o);
    endsequence
    a_pp_rise: assert property (s_clean ##0 (mode_i == PPW_MODE_PP && rise_evt_i)
        |-> ##2 ($past(odd_period_o, 2) ? pwm_out_a_o : pwm_out_b_o)) else $error("rise missed");
    a_pp_fall: assert property (s_clean ##0 (mode_i == PPW_MODE_PP && fall_evt_i)
        |-> ##2 !($past(odd_period_o, 2) ? pwm_out_a_o : pwm_out_b_o)) else $error("fall missed");
    a_pair_equal: assert property (s_clean ##0 (mode_i inside {PPW_MODE_PP_FB4,
        PPW_MODE_PP_FB6}) |-> pins[0] == pins[2] && pins[1] == pins[3]) else $error("pair differs");
    a_unused_idle: assert property (s_clean |->
        !(mode_i inside {PPW_MODE_PP, PPW_MODE_SKIP_CMP} && pins[5:2] != 4'h0)
        && !(mode_i == PPW_MODE_PP_FB4 && pins[5:4] != 2'h0)
        && !(mode_i == PPW_MODE_PP_COMP && pins[3:2] != 2'h0)
        && !(mode_i == PPW_MODE_SKIP && pins[5:1] != 5'h00)) else $error("unused pin active");
    a_no_overlap: assert property (s_clean |->
        !(mode_i inside {PPW_MODE_PP_COMP, PPW_MODE_PP_FB6} && (pins[0] && pins[4] || pins[1] && pins[5]))
        && !(mode_i == PPW_MODE_SKIP_CMP && pins[0] && pins[1])) else $error("pair overlap");
    a_skip_armed: assert property (s_skip ##0 qual ##1 phase_rise_evt_i
        |-> ##2 pwm_out_a_o) else $error("armed pulse missed");
    a_skip_unqual: assert property (s_skip ##0 !qual ##1 phase_rise_evt_i
        |-> ##2 !pwm_out_a_o) else $error("unqualified pulse");
    a_skip_fall: assert property (s_clean ##0 (mode_i inside {PPW_MODE_SKIP,
        PPW_MODE_SKIP_CMP} && fall_evt_i) |-> ##2 !pwm_out_a_o) else $error("skip fall missed");
    a_disabled_pol: assert property (!enable_i [*4] ##0 $stable(polarity_i)
        |-> pins == polarity_i) else $error("polarity wrong");
    a_parity_start: assert property (!enable_i ##1 enable_i |-> odd_period_o)
        else $error("parity not odd");
endmodule : ppw_gen_props
bind ppw_gen ppw_gen_props #(.NUM_SRC(NUM_SRC)) u_props (
    .core_clk_i, .sys_rst_i, .enable_i, .mode_i, .polarity_i, .period_evt_i,
    .rise_evt_i, .fall_evt_i, .rise_src_i, .rise_src_en_i, .phase_rise_evt_i,
    .odd_period_o, .pwm_out_a_o, .pwm_out_b_o, .pwm_out_c_o, .pwm_out_d_o,
    .pwm_out_e_o, .pwm_out_f_o
);
`default_nettype wire

// ### test/push_pull_pulse_skip_pwm_modes_tb.sv
// Self-checking bench for the push-pull and pulse-skipping generator
`timescale 1ns/1ps
`default_nettype none
module push_pull_pulse_skip_pwm_modes_tb;
    import ppw_pkg::*;
    logic       core_clk_i = 1'b0;
    logic       sys_rst_i = 1'b1;
    logic       enable_i = 1'b0;
    ppw_mode_e  mode_i = PPW_MODE_PP;
    logic [5:0] polarity_i = 6'h00;
    logic [3:0] evt = 4'h0;
    logic [3:0] rise_src_i = 4'h0;
    logic [3:0] rise_src_en_i = 4'h0;
    logic       db_rise_en_i = 1'b1;
    logic       db_fall_en_i = 1'b1;
    logic       odd_period_o;
    wire  [5:0] pins;
    logic [5:0] gate;
    logic [5:0] w = 6'h00;
    logic [5:0] last = 6'h00;
    logic [5:0] pm;
    logic [5:0] cm;
    logic       odd = 1'b1;
    logic       first = 1'b1;
    logic [5:0] exp_q[$];
    int         n_fail = 0;
    int         compares = 0;
    int         seed = 32'h2105;

    always #25 core_clk_i = ~core_clk_i;

    ppw_gen #(.NUM_SRC(4)) uut (
        .core_clk_i, .sys_rst_i, .enable_i, .mode_i, .polarity_i,
        .db_rise_en_i, .db_fall_en_i,
        .db_rise_time_i(8'h03), .db_fall_time_i(8'h02),
        .period_evt_i(evt[0]), .rise_evt_i(evt[1]), .fall_evt_i(evt[2]),
        .phase_rise_evt_i(evt[3]), .rise_src_i, .rise_src_en_i, .odd_period_o,
        .pwm_out_a_o(pins[0]), .pwm_out_b_o(pins[1]), .pwm_out_c_o(pins[2]),
        .pwm_out_d_o(pins[3]), .pwm_out_e_o(pins[4]), .pwm_out_f_o(pins[5])
    );
    ppw_gate_drv u_gate (.core_clk_i, .pin_i(pins), .gate_o(gate));

    task automatic chk(input logic [5:0] seen, input logic [5:0] want);
        compares++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask : chk

    task automatic report_and_stop;
        if (n_fail == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : report_and_stop

    // Note a new wave state as the pins should show it
    task automatic push(input logic [5:0] nw);
        if (nw != w) begin
            w = nw;
            exp_q.push_back(w ^ polarity_i);
        end
    endtask : push

    task automatic step(input logic [3:0] v);
        evt = v;
        @(negedge core_clk_i);
        evt = 4'h0;
        repeat (8) @(negedge core_clk_i);
    endtask : step

    task automatic masks;
        pm = odd ? 6'h01 : 6'h02;
        if (mode_i inside {PPW_MODE_PP_FB4, PPW_MODE_PP_FB6}) pm = odd ? 6'h05 : 6'h0a;
        if (mode_i inside {PPW_MODE_SKIP, PPW_MODE_SKIP_CMP}) pm = 6'h01;
        cm = 6'h00;
        if (mode_i inside {PPW_MODE_PP_COMP, PPW_MODE_PP_FB6}) cm = odd ? 6'h10 : 6'h20;
        if (mode_i == PPW_MODE_SKIP_CMP) cm = 6'h02;
    endtask : masks

    task automatic next_parity;
        odd = first ? odd : !odd;
        first = 1'b0;
        chk({5'h00, odd_period_o}, {5'h00, odd});
    endtask : next_parity

    // Without a dead band the complement and primary swap in one edge
    task automatic rise;
        masks();
        if (db_rise_en_i) push(w & ~cm);
        push((w & ~cm) | pm);
        step(4'h2);
    endtask : rise

    task automatic fall;
        masks();
        if (db_fall_en_i) push(w & ~pm);
        push((w & ~pm) | cm);
        step(4'h4);
    endtask : fall

    // Period with or without a qualifying source, then the phase event
    task automatic skip(input logic q);
        rise_src_en_i = 4'($random(seed)) | 4'h1;
        rise_src_i = q ? 4'($random(seed)) | rise_src_en_i : ~rise_src_en_i;
        step(4'h2);
        evt = 4'h1;
        @(negedge core_clk_i);
        if (q) begin
            masks();
            if (db_rise_en_i) push(w & ~cm);
            push((w & ~cm) | pm);
        end
        step(4'h8);
        next_parity();
    endtask : skip

    task automatic setup(input ppw_mode_e m, input logic [5:0] p);
        enable_i = 1'b0;
        push(6'h00);
        repeat (4) @(negedge core_clk_i);
        mode_i = m;
        if (p != polarity_i) exp_q.push_back(p);
        polarity_i = p;
        repeat (4) @(negedge core_clk_i);
        enable_i = 1'b1;
        {odd, first} = 2'b11;
        if (m inside {PPW_MODE_PP_COMP, PPW_MODE_PP_FB6}) push(6'h30);
        if (m == PPW_MODE_SKIP_CMP) push(6'h02);
        repeat (4) @(negedge core_clk_i);
        chk({5'h00, odd_period_o}, 6'h01);
    endtask : setup

    always @(negedge core_clk_i) begin
        if (!sys_rst_i && gate !== last) begin
            last = gate;
            chk(gate, (exp_q.size() > 0) ? exp_q.pop_front() : ~gate);
        end
    end

    initial begin
        repeat (6) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 6; i++) begin
            setup(ppw_mode_e'(i[2:0]), 6'h00);
            if (i >= 4) begin
                skip(1'b1);
                fall();
                skip(1'b0);
                skip(1'b1);
                fall();
            end else begin
                repeat (3) begin
                    step(4'h1);
                    next_parity();
                    rise();
                    rise();
                    fall();
                end
            end
        end
        setup(PPW_MODE_PP_FB6, 6'($random(seed)));
        {db_rise_en_i, db_fall_en_i} = 2'b00;
        repeat (2) begin
            step(4'h1);
            next_parity();
            rise();
            fall();
        end
        setup(PPW_MODE_PP, 6'h00);
        for (int k = 0; k < 50 && exp_q.size() > 0; k++) @(negedge core_clk_i);
        if (exp_q.size() > 0) n_fail++;
        report_and_stop();
    end
endmodule : push_pull_pulse_skip_pwm_modes_tb
`default_nettype wire
